// >>> inc/fbw_pkg.sv
// Constants for the fieldbus writable parameter bank
`default_nettype none
package fbw_pkg;
  localparam int          IMAGE_WORDS    = 32;
  localparam int          IMAGE_BYTES    = 2 * IMAGE_WORDS;
  localparam int          BYTE_CNT_W     = 7;
  localparam int          WORD_IDX_W     = 5;
  // Byte offsets within the master output image
  localparam int          UNUSED0_OFS    = 0;
  localparam int          UNUSED1_OFS    = 2;
  localparam int          CMD_OFS        = 4;
  localparam int          SP_OFS         = 6;
  localparam int          OSC_OFS        = 8;
  localparam logic [4:0]  CMD_IDX        = 5'(CMD_OFS / 2);
  localparam logic [4:0]  SP_IDX         = 5'(SP_OFS / 2);
  localparam logic [4:0]  OSC_IDX        = 5'(OSC_OFS / 2);
  // Command word fields
  localparam int          CMD_SP_LOCAL   = 1;
  localparam int          CMD_OUT_EN     = 2;
  localparam int          CMD_IL_LOCAL   = 4;
  localparam logic [15:0] CMD_MASK       = 16'h0016;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  // Parameter ceilings; minimum is always zero
  localparam logic [15:0] SP_MAX         = 16'h03FF;
  localparam logic [15:0] OSC_MAX        = 16'h00FF;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
endpackage
`default_nettype wire

// >>> inc/word_bus_if.sv
// Assembled-word carrier between byte pairer and register bank
`timescale 1ns/1ps
`default_nettype none
interface word_bus_if;
  logic        wr;
  logic [4:0]  idx;
  logic [15:0] data;
  modport src (output wr, idx, data);
  modport dst (input wr, idx, data);
endinterface
`default_nettype wire

// >>> core/byte_pairer.sv
// Pairs output-image bytes into words, high byte first
`timescale 1ns/1ps
`default_nettype none
module byte_pairer
  import fbw_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       frame_start_i,
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_i,
  word_bus_if.src         wb
);
  logic [BYTE_CNT_W-1:0] cnt_q;
  logic [BYTE_CNT_W-1:0] cnt_base;
  logic [7:0]            hi_q;
  logic                  in_image;
  logic                  take;

  // A new frame restarts at byte zero even if the old one was short
  assign cnt_base = frame_start_i ? '0 : cnt_q;
  assign in_image = cnt_base < BYTE_CNT_W'(IMAGE_BYTES);
  assign take     = byte_valid_i && in_image;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q   <= '0;
      hi_q    <= 8'h00;
      wb.wr   <= 1'b0;
      wb.idx  <= '0;
      wb.data <= WORD_RESET;
    end else begin
      wb.wr <= take && cnt_base[0];
      if (take) begin
        cnt_q <= cnt_base + BYTE_CNT_W'(1);
      end else begin
        cnt_q <= cnt_base;
      end
      if (take && !cnt_base[0]) begin
        hi_q <= byte_i;
      end
      if (take && cnt_base[0]) begin
        wb.idx  <= cnt_base[WORD_IDX_W:1];
        wb.data <= {hi_q, byte_i};
      end
    end
  end

  AST_HI_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (take && cnt_base[0]) |=> (wb.wr && wb.data == {$past(hi_q), $past(byte_i)}))
    else $error("word not formed high byte first");
  AST_CYCLIC_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wb.wr |-> $past(byte_valid_i))
    else $error("word written without a cyclic byte");
  AST_IMAGE_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= BYTE_CNT_W'(IMAGE_BYTES))
    else $error("byte count ran past the output image");
endmodule
`default_nettype wire

// >>> core/fieldbus_write_parameter_map.sv
// Writable parameter bank fed by the cyclic fieldbus output image
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Parameters arrive only through cyclic data exchange; no acyclic services.
// - Output image toward the device spans 32 sixteen-bit words.
// - Command word at byte 4: bit1 local set point, bit2 enable, bit4 local limit.
// - Parameters are unsigned, zero minimum, held to their listed maximum.
// - With read-write access, set-point source follows command bit 1 only.
// - With read-write and input enabling, output needs digital input and bit 2.
// - Words travel high byte first, then low byte.
// - Zero command word selects analog limit; analog set point only with read-write or no set-point input.
module fieldbus_write_parameter_map
  import fbw_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       frame_start_i,
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       port2_rw_i,
  input  wire logic       sp_di_cfg_i,
  input  wire logic       sp_di_local_i,
  input  wire logic       out_di_cfg_i,
  input  wire logic       out_di_on_i,
  output logic [15:0]     command_word_o,
  output logic [9:0]      set_point_o,
  output logic [7:0]      output_scale_o,
  output logic            sp_local_o,
  output logic            out_enable_o,
  output logic            il_local_o
);
  word_bus_if wb ();

  byte_pairer u_pairer (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .frame_start_i (frame_start_i),
    .byte_valid_i  (byte_valid_i),
    .byte_i        (byte_i),
    .wb            (wb)
  );

  logic [15:0] cmd_q;
  logic [15:0] sp_q;
  logic [15:0] osc_q;
  logic        wr_cmd;
  logic        wr_sp;
  logic        wr_osc;
  logic [15:0] cmd_d;
  logic [15:0] sp_d;
  logic [15:0] osc_d;
  logic        sp_local_d;
  logic        out_en_d;
  logic        il_local_d;

  // Words at indices 0, 1 and 5..31 fall through with no decode
  assign wr_cmd = wb.wr && (wb.idx == CMD_IDX);
  assign wr_sp  = wb.wr && (wb.idx == SP_IDX);
  assign wr_osc = wb.wr && (wb.idx == OSC_IDX);
  assign cmd_d  = wr_cmd ? (wb.data & CMD_MASK) : cmd_q;
  // Saturate rather than wrap so an out-of-range write cannot go low
  assign sp_d   = !wr_sp ? sp_q : ((wb.data > SP_MAX) ? SP_MAX : wb.data);
  assign osc_d  = !wr_osc ? osc_q : ((wb.data > OSC_MAX) ? OSC_MAX : wb.data);

  // Without read-write access the digital input keeps its say
  assign sp_local_d = (port2_rw_i || !sp_di_cfg_i) ? cmd_q[CMD_SP_LOCAL]
                                                   : sp_di_local_i;
  assign out_en_d   = !port2_rw_i ? (!out_di_cfg_i || out_di_on_i)
                    : out_di_cfg_i ? (out_di_on_i && cmd_q[CMD_OUT_EN])
                    : cmd_q[CMD_OUT_EN];
  assign il_local_d = cmd_q[CMD_IL_LOCAL];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RESET;
      sp_q  <= WORD_RESET;
      osc_q <= WORD_RESET;
    end else begin
      cmd_q <= cmd_d;
      sp_q  <= sp_d;
      osc_q <= osc_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sp_local_o   <= 1'b0;
      out_enable_o <= 1'b0;
      il_local_o   <= 1'b0;
    end else begin
      sp_local_o   <= sp_local_d;
      out_enable_o <= out_en_d;
      il_local_o   <= il_local_d;
    end
  end

  assign command_word_o = cmd_q;
  assign set_point_o    = sp_q[9:0];
  assign output_scale_o = osc_q[7:0];

  AST_CMD_DECODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_cmd |=> (cmd_q == ($past(wb.data) & CMD_MASK)))
    else $error("command word not stored with its used bits");
  AST_CMD_FIELDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_cmd && port2_rw_i) ##1 port2_rw_i |=>
      (sp_local_o == $past(cmd_q[CMD_SP_LOCAL], 1) && il_local_o == $past(cmd_q[CMD_IL_LOCAL])))
    else $error("command bits 1 or 4 not reflected");
  AST_CLAMP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sp_q <= SP_MAX) && (osc_q <= OSC_MAX))
    else $error("parameter above its ceiling");
  AST_SP_SAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_sp && wb.data > SP_MAX) |=> (sp_q == SP_MAX))
    else $error("set point not saturated");
  AST_RW_LOCAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    port2_rw_i |=> (sp_local_o == $past(cmd_q[CMD_SP_LOCAL])))
    else $error("set point source ignores command bit 1");
  AST_EN_BOTH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (port2_rw_i && out_di_cfg_i) |=> (out_enable_o == $past(out_di_on_i && cmd_q[CMD_OUT_EN])))
    else $error("output enable not gated by input and bit 2");
  AST_ZERO_ANALOG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_q == CMD_RESET && (port2_rw_i || !sp_di_cfg_i)) |=> (!sp_local_o && !il_local_o))
    else $error("zero command does not select analog sources");
  AST_UNUSED_WORD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wb.wr && wb.idx != CMD_IDX && wb.idx != SP_IDX && wb.idx != OSC_IDX)
      |=> ($stable(cmd_q) && $stable(sp_q) && $stable(osc_q)))
    else $error("unused word changed a parameter");

  COV_CMD_WRITE: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_cmd);
  COV_SP_SAT: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_sp && wb.data > SP_MAX);
  COV_EN_BOTH: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    port2_rw_i && out_di_cfg_i && out_enable_o);
endmodule
`default_nettype wire

// >>> verif/fb_master.sv
// Fieldbus master model sending cyclic output images
`timescale 1ns/1ps
`default_nettype none
module fb_master (
  input  wire logic       clk_i,
  output logic            frame_start_o,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);
  initial begin
    frame_start_o = 1'b0;
    byte_valid_o  = 1'b0;
    byte_o        = 8'h00;
  end
  // Idle byte line flips so a stale value never looks valid
  task automatic idle();
    @(posedge clk_i);
    #1;
    frame_start_o = 1'b0;
    byte_valid_o  = 1'b0;
    byte_o        = ~byte_o;
  endtask
  // Cyclic image only; station address resolved upstream
  // Bytes past the 64-byte image come inverted so a wrongly taken one shows
  task automatic send_image(input logic [79:0] img, input int gap, input int n);
    for (int i = 0; i < n; i++) begin
      int         k;
      logic [7:0] inv;
      k   = i % 64;
      inv = (i >= 64) ? 8'hFF : 8'h00;
      @(posedge clk_i);
      #1;
      frame_start_o = (i == 0);
      byte_valid_o  = 1'b1;
      byte_o        = inv ^ ((k < 10) ? img[79 - 8 * k -: 8] : 8'h00);
      for (int g = 0; g < gap; g++) idle();
    end
    idle();
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the writable parameter bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb;
  import fbw_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        fs, bv, rw, spc, spd, oc, od;
  logic [7:0]  bt;
  logic [15:0] cw;
  logic [9:0]  sp;
  logic [7:0]  os;
  logic        spl, oen, ill;
  int          errors = 0;
  int          compares = 0;
  initial {rw, spc, spd, oc, od} = 5'h00;
  always #25 clk_i = ~clk_i;
  fb_master fb_master_i (.clk_i(clk_i), .frame_start_o(fs), .byte_valid_o(bv), .byte_o(bt));
  fieldbus_write_parameter_map fieldbus_write_parameter_map_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .frame_start_i(fs), .byte_valid_i(bv), .byte_i(bt),
    .port2_rw_i(rw), .sp_di_cfg_i(spc), .sp_di_local_i(spd), .out_di_cfg_i(oc),
    .out_di_on_i(od), .command_word_o(cw), .set_point_o(sp), .output_scale_o(os),
    .sp_local_o(spl), .out_enable_o(oen), .il_local_o(ill));
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic run(input string nm, input logic [15:0] cmd, input logic [15:0] spw,
                     input logic [15:0] osw, input logic [4:0] cfg, input int gap, input int n);
    logic [15:0] c;
    logic [9:0]  s;
    logic [7:0]  o;
    {rw, spc, spd, oc, od} = cfg;
    // Junk in the unused words must not leak anywhere
    fb_master_i.send_image({16'hA5A5, 16'h5A5A, cmd, spw, osw}, gap, n);
    repeat (4) @(posedge clk_i);
    #1;
    c = cmd & CMD_MASK;
    s = 10'((spw > SP_MAX) ? SP_MAX : spw);
    o = 8'((osw > OSC_MAX) ? OSC_MAX : osw);
    `CHK("command", c, cw)
    `CHK("set_point", s, sp)
    `CHK("out_scale", o, os)
    `CHK("sp_local", (rw | !spc) ? c[1] : spd, spl)
    `CHK("out_en", !rw ? (!oc | od) : (oc ? (od & c[2]) : c[2]), oen)
    `CHK("il_local", c[4], ill)
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    `CHK("rst_cmd", CMD_RESET, cw)
    `CHK("rst_sp", 10'h000, sp)
    `CHK("rst_osc", 8'h00, os)
    `CHK("rst_flags", 3'h0, {spl, oen, ill})
    run("mask", 16'hFFFF, 16'h0155, 16'h0080, 5'h10, 0, 64);
    run("saturate", 16'h0004, 16'hFFFF, 16'h1234, 5'h00, 2, 64);
    run("zero_cmd", 16'h0000, 16'h03FF, 16'h00FF, 5'h10, 1, 64);
    // A cut frame leaves its odd byte unpaired; the next frame must realign
    fb_master_i.send_image({16'h0000, 16'h0000, 16'hFF00, 16'h0000, 16'h0000}, 0, 5);
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("short_frame", 16'h0000, cw)
    $display("test short_frame done");
    run("rw_sp_bit", 16'h0002, 16'h0200, 16'h0011, 5'h18, 0, 64);
    run("di_sp", 16'h0000, 16'h0001, 16'h0001, 5'h0C, 0, 64);
    run("di_and_bit", 16'h0004, 16'h0002, 16'h0002, 5'h13, 0, 64);
    // Bytes 68 and 69 would land on the command word if taken
    run("di_off_long", 16'h0014, 16'h0003, 16'h0003, 5'h12, 3, 70);
    run("bit_off", 16'h0010, 16'h0004, 16'h0004, 5'h13, 0, 64);
    finish_test();
  end
endmodule
`default_nettype wire
